// ### design/burst_sram_pkg.sv
// shared constants and types for the pipelined burst sram control block
// Functional notes
// - strobe-c write needs full select and write term
// - strobe-c write completes in one cycle
// - begin loads address and counter, ignores advance
// - global write writes every byte lane
// - byte write touches only selected lanes
// - any write cycle turns data drivers off
// - two-bit wraparound counter supplies low address bits
// - advance low steps counter in continuing cycles
// - interleaved order: start xor beat
// - linear order: start plus beat modulo four
// - async sleep within two cycles, pins off
// - sleep keeps memory, abandons pending access
// - deselect conditions float the data pins
// - proc strobe begins read, ignores write inputs
// - ctrl strobe begins write or read burst
// - advance low continues burst at next address
// - advance high repeats access at current address
// - write term: global write or enabled lane
// - output enable gates reads, masked in writes
// - read data one edge later, first cycle floats
// - proc strobe write samples data at second edge
// - strap low linear, high interleaved, static
package burst_sram_pkg;
  // ==========================================================
  // sizes
  localparam int LANE_W = 8;
  localparam int LANES_DEF = 4;
  localparam int ADDR_W_DEF = 10;
  localparam int BURST_W = 2;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLEEP_ENTRY_NS = 2 * CLK_PERIOD_NS;
  localparam int SLEEP_ENTRY_CYCLES = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // reset values
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic SYNC_RST = 1'b0;
  localparam logic OE_N_RST = 1'b1;
  localparam logic STRAP_RST = 1'b1;
  // ==========================================================
  // access state
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BURST = 1'b1
  } access_state_e;
endpackage

// ### design/burst_ctr_if.sv
// carrier between the access control and the burst counter
interface burst_ctr_if;
  import burst_sram_pkg::*;
  logic load;
  logic advance;
  logic linear_mode;
  logic [BURST_W-1:0] load_value;
  logic [BURST_W-1:0] cur_lsbs;
  logic [BURST_W-1:0] nxt_lsbs;
  modport ctrl (output load, output advance, output linear_mode, output load_value,
    input cur_lsbs, input nxt_lsbs);
  modport ctr (input load, input advance, input linear_mode, input load_value,
    output cur_lsbs, output nxt_lsbs);
endinterface

// ### design/burst_counter.sv
// two-bit wraparound burst counter with interleaved or linear order
module burst_counter
  import burst_sram_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  burst_ctr_if.ctr bus
);
  logic [BURST_W-1:0] start_reg;
  logic [BURST_W-1:0] start_next;
  logic [BURST_W-1:0] beat_reg;
  logic [BURST_W-1:0] beat_next;
  logic [BURST_W-1:0] beat_inc;

  // ==========================================================
  // counter state
  always_comb
  begin
    beat_inc = beat_reg + 2'h1;
    start_next = start_reg;
    beat_next = beat_reg;
    if (bus.load)
    begin
      start_next = bus.load_value;
      beat_next = BURST_RST;
    end
    else if (bus.advance)
    begin
      beat_next = beat_inc;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      start_reg <= BURST_RST;
      beat_reg <= BURST_RST;
    end
    else
    begin
      start_reg <= start_next;
      beat_reg <= beat_next;
    end
  end

  // order mapping: beat index combined with the start value
  assign bus.cur_lsbs = bus.linear_mode ? start_reg + beat_reg : start_reg ^ beat_reg;
  assign bus.nxt_lsbs = bus.linear_mode ? start_reg + beat_inc : start_reg ^ beat_inc;

  // ==========================================================
  // checks
  property p_load;
    @(posedge clk_sys_i) disable iff (rst_i)
    bus.load |=> beat_reg == 2'h0 && start_reg == $past(bus.load_value);
  endproperty
  a_load: assert property (p_load) else $error("counter did not load start");

  property p_step;
    @(posedge clk_sys_i) disable iff (rst_i)
    bus.advance && !bus.load |=> beat_reg == $past(beat_reg) + 2'h1;
  endproperty
  a_step: assert property (p_step) else $error("counter did not step");

  property p_interleave;
    @(posedge clk_sys_i) disable iff (rst_i)
    !bus.linear_mode && bus.load ##1 !bus.linear_mode && bus.advance && !bus.load
      |=> bus.cur_lsbs == ($past(bus.load_value, 2) ^ 2'h1);
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleaved order wrong");

  property p_linear_wrap;
    @(posedge clk_sys_i) disable iff (rst_i)
    bus.linear_mode && bus.advance && !bus.load && $stable(bus.linear_mode)
      |=> bus.cur_lsbs == $past(bus.cur_lsbs) + 2'h1;
  endproperty
  a_linear_wrap: assert property (p_linear_wrap) else $error("linear order wrong");

  c_full_burst: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    bus.load ##1 bus.advance ##1 bus.advance ##1 bus.advance);
endmodule

// ### design/pipelined_burst_sram_control.sv
// access control, memory array and data pin pipeline of the burst sram
module pipelined_burst_sram_control
  import burst_sram_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES = LANES_DEF
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ctrl_addr_strobe_n_i,
  input wire logic proc_addr_strobe_n_i,
  input wire logic burst_advance_n_i,
  input wire logic global_write_n_i,
  input wire logic byte_write_enable_n_i,
  input wire logic [LANES-1:0] byte_lane_select_n_i,
  input wire logic chip_sel_1_n_i,
  input wire logic chip_sel_2_i,
  input wire logic chip_sel_3_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [LANES*LANE_W-1:0] dq_i,
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_order_strap_i,
  output logic [LANES*LANE_W-1:0] dq_o,
  output logic dq_oe_n_o,
  output logic sleep_active_o
);
  localparam int DATA_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  burst_ctr_if ctr_bus ();

  logic [DATA_W-1:0] mem [DEPTH];

  access_state_e state_reg;
  access_state_e state_next;
  logic [ADDR_W-BURST_W-1:0] upper_reg;
  logic [ADDR_W-BURST_W-1:0] upper_next;
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic [DATA_W-1:0] dq_reg;
  logic [DATA_W-1:0] dq_next;
  logic dq_oe_n_reg;
  logic dq_oe_n_next;
  logic sleep_s1_reg;
  logic sleep_s2_reg;
  logic oe_s1_reg;
  logic oe_s2_reg;
  logic strap_s1_reg;
  logic strap_s2_reg;

  logic sel_ok;
  logic proc_go;
  logic deselect;
  logic begin_proc;
  logic begin_ctrl;
  logic wr_term;
  logic cont;
  logic wr_now;
  logic rd_now;
  logic [BURST_W-1:0] eff_lsbs;
  logic [ADDR_W-1:0] eff_addr;
  logic [LANES-1:0] lane_we;
  logic [DATA_W-1:0] wr_word;

  burst_counter u_counter (
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .bus (ctr_bus.ctr)
  );

  // ==========================================================
  // pin synchronisers for the asynchronous inputs
  // sleep, output enable and strap are two flops deep, so output enable
  // takes effect on the pins three edges after it moves
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sleep_s1_reg <= SYNC_RST;
      sleep_s2_reg <= SYNC_RST;
      oe_s1_reg <= OE_N_RST;
      oe_s2_reg <= OE_N_RST;
      strap_s1_reg <= STRAP_RST;
      strap_s2_reg <= STRAP_RST;
    end
    else
    begin
      sleep_s1_reg <= sleep_request_i;
      sleep_s2_reg <= sleep_s1_reg;
      oe_s1_reg <= output_enable_n_i;
      oe_s2_reg <= oe_s1_reg;
      strap_s1_reg <= burst_order_strap_i;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // ==========================================================
  // cycle decode
  always_comb
  begin
    sel_ok = chip_sel_2_i && !chip_sel_3_n_i;
    proc_go = !proc_addr_strobe_n_i && !chip_sel_1_n_i;
    deselect = (chip_sel_1_n_i && !ctrl_addr_strobe_n_i)
      || (!sel_ok && (!ctrl_addr_strobe_n_i || proc_go));
    begin_proc = !sleep_s2_reg && proc_go && sel_ok;
    begin_ctrl = !sleep_s2_reg && !ctrl_addr_strobe_n_i && proc_addr_strobe_n_i
      && !chip_sel_1_n_i && sel_ok;
    wr_term = !global_write_n_i || (!byte_write_enable_n_i && !(&byte_lane_select_n_i));
    cont = !sleep_s2_reg && state_reg == ST_BURST && ctrl_addr_strobe_n_i
      && (proc_addr_strobe_n_i || chip_sel_1_n_i);
    // a proc strobe cycle is always a read; its write lands in the next cycle
    wr_now = (begin_ctrl || cont) && wr_term;
    rd_now = begin_proc || ((begin_ctrl || cont) && !wr_term);
    eff_lsbs = ctr_bus.cur_lsbs;
    if (begin_proc || begin_ctrl)
    begin
      eff_lsbs = addr_i[BURST_W-1:0];
    end
    else if (!burst_advance_n_i)
    begin
      eff_lsbs = ctr_bus.nxt_lsbs;
    end
    eff_addr = (begin_proc || begin_ctrl) ? addr_i : {upper_reg, eff_lsbs};
  end

  assign ctr_bus.load = begin_proc || begin_ctrl;
  assign ctr_bus.advance = cont && !burst_advance_n_i;
  assign ctr_bus.load_value = addr_i[BURST_W-1:0];
  assign ctr_bus.linear_mode = !strap_s2_reg;

  // ==========================================================
  // byte lane write merge
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      assign lane_we[g] = !global_write_n_i
        || (!byte_write_enable_n_i && !byte_lane_select_n_i[g]);
      assign wr_word[g*LANE_W +: LANE_W] = lane_we[g] ? dq_i[g*LANE_W +: LANE_W]
        : mem[eff_addr][g*LANE_W +: LANE_W];
      property p_lane_keep;
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_now && global_write_n_i && byte_lane_select_n_i[g]
          |=> mem[$past(eff_addr)][g*LANE_W +: LANE_W]
          === $past(mem[eff_addr][g*LANE_W +: LANE_W]);
      endproperty
      a_lane_keep: assert property (p_lane_keep) else $error("unselected lane changed");
    end
  endgenerate

  // array has no reset: contents survive sleep and reset alike
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_now)
    begin
      mem[eff_addr] <= wr_word;
    end
  end

  // ==========================================================
  // access state and data pipeline
  always_comb
  begin
    state_next = state_reg;
    upper_next = upper_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (begin_proc || begin_ctrl)
        begin
          state_next = ST_BURST;
        end
      end
      ST_BURST:
      begin
        if (sleep_s2_reg || (deselect && !begin_proc && !begin_ctrl))
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    if (begin_proc || begin_ctrl)
    begin
      upper_next = addr_i[ADDR_W-1:BURST_W];
    end
    rd_valid_next = rd_now;
    rd_data_next = mem[eff_addr];
    // data reaches the pins one edge after the address; a fresh access
    // from the deselected state therefore floats for its first cycle
    dq_next = rd_valid_reg ? rd_data_reg : dq_reg;
    dq_oe_n_next = !(rd_valid_reg && !oe_s2_reg && !sleep_s2_reg
      && !wr_now && !deselect);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      upper_reg <= '0;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= '0;
      dq_reg <= '0;
      dq_oe_n_reg <= OE_N_RST;
    end
    else
    begin
      state_reg <= state_next;
      upper_reg <= upper_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
      dq_reg <= dq_next;
      dq_oe_n_reg <= dq_oe_n_next;
    end
  end

  assign dq_o = dq_reg;
  assign dq_oe_n_o = dq_oe_n_reg;
  assign sleep_active_o = sleep_s2_reg;

  // ==========================================================
  // checks
  property p_write_float;
    @(posedge clk_sys_i) disable iff (rst_i)
    wr_now |=> dq_oe_n_o;
  endproperty
  a_write_float: assert property (p_write_float) else $error("pins driven in write");

  property p_deselect_float;
    @(posedge clk_sys_i) disable iff (rst_i)
    deselect |=> dq_oe_n_o;
  endproperty
  a_deselect_float: assert property (p_deselect_float) else $error("pins driven at deselect");

  property p_proc_read;
    @(posedge clk_sys_i) disable iff (rst_i)
    begin_proc |-> rd_now && !wr_now;
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("proc strobe did not read");

  property p_global_write;
    @(posedge clk_sys_i) disable iff (rst_i)
    wr_now && !global_write_n_i |=> mem[$past(eff_addr)] == $past(dq_i);
  endproperty
  a_global_write: assert property (p_global_write) else $error("global write lost lanes");

  property p_ctrl_write;
    @(posedge clk_sys_i) disable iff (rst_i)
    begin_ctrl && wr_term |-> wr_now ##1 state_reg == ST_BURST;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write not one cycle");

  property p_oe_gate;
    @(posedge clk_sys_i) disable iff (rst_i)
    oe_s2_reg |=> dq_oe_n_o;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("pins driven with enable high");

  property p_sleep_entry;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(sleep_request_i) ##1 sleep_request_i |-> ##1 sleep_active_o ##1 dq_oe_n_o;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry too slow");

  property p_upper_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
    state_reg == ST_BURST && !begin_proc && !begin_ctrl |=> $stable(upper_reg);
  endproperty
  a_upper_hold: assert property (p_upper_hold) else $error("upper address moved");

  property p_read_latency;
    @(posedge clk_sys_i) disable iff (rst_i)
    rd_now |=> ##1 dq_o == $past(rd_data_reg);
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read data late");

  property p_proc_keep;
    @(posedge clk_sys_i) disable iff (rst_i)
    begin_proc |=> mem[$past(eff_addr)] === $past(mem[eff_addr]);
  endproperty
  a_proc_keep: assert property (p_proc_keep) else $error("proc strobe begin wrote");

  property p_sleep_idle;
    @(posedge clk_sys_i) disable iff (rst_i)
    sleep_s2_reg |=> state_reg == ST_IDLE;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("access kept in sleep");

  property p_sleep_pins;
    @(posedge clk_sys_i) disable iff (rst_i)
    sleep_active_o |=> dq_oe_n_o;
  endproperty
  a_sleep_pins: assert property (p_sleep_pins) else $error("pins driven in sleep");

  property p_begin_upper;
    @(posedge clk_sys_i) disable iff (rst_i)
    begin_proc || begin_ctrl |=> upper_reg == $past(addr_i[ADDR_W-1:BURST_W]);
  endproperty
  a_begin_upper: assert property (p_begin_upper) else $error("upper address not captured");

  c_proc_write: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    begin_proc ##1 (cont && wr_term));
  c_read_burst: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    begin_ctrl && !wr_term ##1 (cont && !burst_advance_n_i) ##2 !dq_oe_n_o);
  c_sleep: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(sleep_active_o));
endmodule

// ### verification/bus_master_model.sv
// bus master model driving the access, select, enable and sleep pins of the sram
module bus_master_model
  import burst_sram_pkg::*;
(
  input wire logic clk_sys_i,
  output logic cstb_n_o,
  output logic pstb_n_o,
  output logic step_n_o,
  output logic allw_n_o,
  output logic bytew_n_o,
  output logic [LANES_DEF-1:0] lane_n_o,
  output logic cs1_n_o,
  output logic cs2_o,
  output logic cs3_n_o,
  output logic [ADDR_W_DEF-1:0] addr_o,
  output logic [LANES_DEF*LANE_W-1:0] wdata_o,
  output logic oe_n_o,
  output logic sleep_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {cstb_n_o, pstb_n_o, step_n_o, allw_n_o, bytew_n_o, oe_n_o} = 6'h3f;
    lane_n_o = 4'hf;
    {cs1_n_o, cs2_o, cs3_n_o} = 3'h2;
    addr_o = 10'h000;
    wdata_o = 32'h0;
    sleep_o = 1'b0;
  end
  // ==========================================================
  // one bus cycle: pins move after a falling edge, held over the next rising edge
  task automatic op(input logic c, input logic p, input logic s, input logic g,
    input logic b, input logic [3:0] l, input logic [9:0] a, input logic [31:0] d);
    cstb_n_o = c;
    pstb_n_o = p;
    step_n_o = s;
    allw_n_o = g;
    bytew_n_o = b;
    lane_n_o = l;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_sys_i);
  endtask
  task automatic idle(input int n);
    // released data lines flip every cycle so a stale value is never seen as good
    repeat (n)
    begin
      op(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, addr_o, ~wdata_o);
    end
  endtask
  task automatic sel(input logic on);
    {cs1_n_o, cs2_o, cs3_n_o} = {~on, on, ~on};
  endtask
  task automatic sel3(input logic c1_n, input logic c2, input logic c3_n);
    {cs1_n_o, cs2_o, cs3_n_o} = {c1_n, c2, c3_n};
  endtask
  task automatic oe(input logic off);
    oe_n_o = off;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic g,
    input logic [3:0] l);
    oe_n_o = 1'b1;
    idle(1);
    op(1'b0, 1'b1, 1'b1, g, ~g, l, a, d);
  endtask
  task automatic sleep_enter();
    sel(1'b0);
    idle(1);
    sleep_o = 1'b1;
  endtask
  task automatic sleep_exit();
    sleep_o = 1'b0;
    idle(3);
    sel(1'b1);
  endtask
endmodule

// ### verification/pipelined_burst_sram_control_tb.sv
// self-checking bench for the pipelined burst sram control block
module pipelined_burst_sram_control_tb
  import burst_sram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, strap, cstb_n, pstb_n, step_n, allw_n, bytew_n, cs1_n, cs2, cs3_n;
  logic oe_n, sleep_req, dq_oe_n, sleep_act;
  logic [3:0] lane_n;
  logic [9:0] addr;
  logic [31:0] wdata, rdata;
  logic [31:0] mem_m [int];
  int bad_count = 0;
  int total_checks = 0;
  bus_master_model master (.clk_sys_i(clk), .cstb_n_o(cstb_n), .pstb_n_o(pstb_n),
    .step_n_o(step_n), .allw_n_o(allw_n), .bytew_n_o(bytew_n), .lane_n_o(lane_n),
    .cs1_n_o(cs1_n), .cs2_o(cs2), .cs3_n_o(cs3_n), .addr_o(addr), .wdata_o(wdata),
    .oe_n_o(oe_n), .sleep_o(sleep_req));
  pipelined_burst_sram_control dut (.clk_sys_i(clk), .rst_i(rst),
    .ctrl_addr_strobe_n_i(cstb_n), .proc_addr_strobe_n_i(pstb_n),
    .burst_advance_n_i(step_n), .global_write_n_i(allw_n),
    .byte_write_enable_n_i(bytew_n), .byte_lane_select_n_i(lane_n),
    .chip_sel_1_n_i(cs1_n), .chip_sel_2_i(cs2), .chip_sel_3_n_i(cs3_n), .addr_i(addr),
    .dq_i(wdata), .output_enable_n_i(oe_n), .sleep_request_i(sleep_req),
    .burst_order_strap_i(strap), .dq_o(rdata), .dq_oe_n_o(dq_oe_n),
    .sleep_active_o(sleep_act));
  initial
  begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  // ==========================================================
  // checking and closing
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_burst(input logic [9:0] a, input logic lin);
    logic [1:0] lsb;
    master.oe(1'b0);
    master.idle(4);
    master.op(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 4'hf, a, 32'h0);
    // a fifth beat shows the wrap; the outside address is scrambled on purpose
    for (int k = 0; k < 5; k++)
    begin
      lsb = lin ? a[1:0] + 2'(k) : a[1:0] ^ 2'(k);
      master.op(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hf, ~a, 32'h0);
      cmp("burst data", mem_m[int'({a[9:2], lsb})], rdata);
      cmp_bit("burst drive", 1'b0, dq_oe_n);
    end
  endtask
  task automatic t_single(input logic [9:0] a);
    master.oe(1'b0);
    master.idle(4);
    master.op(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, a, 32'h0);
    master.op(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, ~a, 32'h0);
    cmp("single data", mem_m[int'(a)], rdata);
  endtask
  task automatic t_writes();
    for (int k = 0; k < 4; k++)
    begin
      master.wr(10'h040 + 10'(k), 32'h5a00_0000 + 32'(k * 32'h0101), 1'b0, 4'hf);
      mem_m[int'(10'h040 + 10'(k))] = 32'h5a00_0000 + 32'(k * 32'h0101);
      cmp_bit("write drive", 1'b1, dq_oe_n);
    end
    master.wr(10'h041, 32'hffff_ffff, 1'b1, 4'b1010);
    mem_m[int'(10'h041)] = mem_m[int'(10'h041)] | 32'h00ff_00ff;
    master.wr(10'h051, 32'h1357_2468, 1'b0, 4'hf);
    mem_m[int'(10'h051)] = 32'h1357_2468;
    // begin with write inputs active must still be a read, then a read repeat
    master.op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 10'h051, 32'hdead_beef);
    master.op(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 10'h000, 32'h0);
    master.op(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 10'h050, 32'h0);
    master.op(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 4'hf, 10'h3ff, 32'h0bad_f00d);
    mem_m[int'(10'h050)] = 32'h0bad_f00d;
    master.idle(1);
    t_single(10'h051);
    t_single(10'h050);
  endtask
  task automatic t_suspend();
    master.oe(1'b0);
    master.idle(4);
    master.op(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 10'h042, 32'h0);
    master.op(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 10'h000, 32'h0);
    cmp("suspend first", mem_m[int'(10'h042)], rdata);
    master.op(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hf, 10'h000, 32'h0);
    cmp("suspend repeat", mem_m[int'(10'h042)], rdata);
    master.op(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 10'h000, 32'h0);
    cmp("suspend next", mem_m[int'(10'h043)], rdata);
  endtask
  task automatic t_float();
    master.oe(1'b1);
    master.idle(4);
    master.op(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 10'h040, 32'h0);
    master.op(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 10'h040, 32'h0);
    cmp_bit("drive with oe high", 1'b1, dq_oe_n);
    master.oe(1'b0);
    master.idle(4);
    cmp_bit("drive after oe low", 1'b0, dq_oe_n);
    master.sel(1'b0);
    master.op(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 10'h040, 32'h0);
    cmp_bit("drive after deselect", 1'b1, dq_oe_n);
    // a fresh read after deselect floats one cycle; then deselect by the third select alone
    master.sel(1'b1);
    master.op(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 10'h041, 32'h0);
    cmp_bit("first cycle float", 1'b1, dq_oe_n);
    master.op(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 10'h041, 32'h0);
    cmp_bit("drive before cs3 deselect", 1'b0, dq_oe_n);
    cmp("read after reselect", mem_m[int'(10'h041)], rdata);
    master.sel3(1'b0, 1'b1, 1'b1);
    master.op(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 10'h041, 32'h0);
    cmp_bit("drive after cs3 deselect", 1'b1, dq_oe_n);
    // selects and strobes must not move in the same step as the next task
    master.sel(1'b1);
    master.idle(1);
  endtask
  task automatic t_sleep();
    master.sleep_enter();
    master.idle(SLEEP_ENTRY_CYCLES);
    cmp_bit("sleep flag", 1'b1, sleep_act);
    cmp_bit("sleep drive", 1'b1, dq_oe_n);
    master.sleep_exit();
    master.idle(SLEEP_ENTRY_CYCLES);
    cmp_bit("wake flag", 1'b0, sleep_act);
    t_single(10'h050);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    rst = 1'b1;
    strap = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    master.idle(3);
    t_writes();
    t_burst(10'h041, 1'b0);
    t_suspend();
    t_float();
    t_sleep();
    strap = 1'b0;
    rst = 1'b1;
    master.idle(8);
    rst = 1'b0;
    master.idle(3);
    t_burst(10'h042, 1'b1);
    print_verdict();
  end
  initial
  begin
    #(2000 * CLK_PERIOD_NS);
    bad_count++;
    print_verdict();
  end
endmodule
